// *** inc/fdi_pkg.sv ***
package fdi_pkg;
   // ==========================================================
   // Register indices (documented offsets)
   localparam logic [6:0] OFS_MAIN_CONTROL   = 7'h00;
   localparam logic [6:0] OFS_MOD_PREFILTER  = 7'h01;
   localparam logic [6:0] OFS_CLK_EXPONENT   = 7'h06;
   localparam logic [6:0] OFS_BITRATE_REFDIV = 7'h07;

   // ==========================================================
   // Field positions
   localparam int POS_FRONT_AMP_BYPASS = 7;
   localparam int POS_SYNC_SELECT      = 3;
   localparam int POS_OP_STATE_LO      = 1;
   localparam int POS_PREFILTER_LO     = 0;
   localparam int POS_EXP_HI           = 0;
   localparam int POS_EXP_LO           = 6;
   localparam int POS_REFDIV_LO        = 0;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_MAIN_CONTROL   = 8'h00;
   localparam logic [7:0] RST_MOD_PREFILTER  = 8'h00;
   localparam logic [7:0] RST_CLK_EXPONENT   = 8'h00;
   localparam logic [7:0] RST_BITRATE_REFDIV = 8'h01;

   // ==========================================================
   // Bit-rate divider limits
   localparam logic [2:0] EXP_MAX    = 3'h6;
   localparam logic [2:0] EXP_BASE   = 3'h7;
   localparam logic [5:0] REFDIV_MIN = 6'h01;

   // ==========================================================
   // Operating states and cutoff codes
   typedef enum logic [1:0] {
      OPS_POWER_DOWN = 2'h0,
      OPS_STANDBY    = 2'h1,
      OPS_RECEIVE    = 2'h2,
      OPS_TRANSMIT   = 2'h3
   } fdi_op_state_t;

   localparam logic [1:0] CUT_100K = 2'h0;
   localparam logic [1:0] CUT_150K = 2'h1;
   localparam logic [1:0] CUT_230K = 2'h2;
   localparam logic [1:0] CUT_340K = 2'h3;
endpackage

// *** src/fdi_rate_gen.sv ***
`timescale 1ns/100ps
// ==========================================================
// Bit-rate tick generator: xtal tick / (K * 2^(7-exp))
module fdi_rate_gen #(
   parameter int CW = 13
) (
   input  wire logic       clk_sys,    // System clock
   input  wire logic       rst_sync_n, // Synchronised reset
   input  wire logic       run,        // Enable generator
   input  wire logic       xtal_tick,  // Crystal-rate tick
   input  wire logic [5:0] ref_div,    // Reference divider K
   input  wire logic [2:0] exponent,   // Bit-rate exponent
   output logic            half_tick   // Pulse at twice bit rate
);
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic [CW-1:0] period_half;
   logic [5:0]    k_eff;
   logic [2:0]    e_eff;
   logic          wrap;

   // Out-of-range K or exponent clamped so the divider never stalls
   assign k_eff = (ref_div < fdi_pkg::REFDIV_MIN) ? fdi_pkg::REFDIV_MIN : ref_div;
   assign e_eff = (exponent > fdi_pkg::EXP_MAX) ? fdi_pkg::EXP_MAX : exponent;
   // Half of K * 2^(7-exp): edges twice per bit
   assign period_half = CW'({7'h00, k_eff} << (fdi_pkg::EXP_BASE - e_eff - 3'h1));
   assign wrap        = xtal_tick && (cnt_reg + CW'(1) >= period_half);
   assign cnt_next    = !run ? '0 : (!xtal_tick ? cnt_reg : (wrap ? '0 : cnt_reg + CW'(1)));

   // Divider counter
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cnt_reg   <= '0;
         half_tick <= 1'b0;
      end else begin
         cnt_reg   <= cnt_next;
         half_tick <= run && wrap;
      end
   end
endmodule // fdi_rate_gen

// *** src/fdi_data_if.sv ***
`timescale 1ns/100ps
module fdi_data_if #(
   parameter int CW = 13
) (
   input  wire logic       clk_sys,         // System clock
   input  wire logic       rst_n,           // Async reset, active low
   input  wire logic       xtal_tick,       // Crystal-rate tick
   input  wire logic       reg_wr,          // Register write strobe
   input  wire logic [6:0] reg_addr,        // Register index
   input  wire logic [7:0] reg_wdata,       // Register write data
   output logic      [7:0] reg_rdata,       // Register read data
   input  wire logic       demod_i_lags_q,  // Phase detector: I lags Q
   input  wire logic       serial_data_in,  // Data pin input
   output logic            serial_data_out, // Data pin output
   output logic            serial_data_oe,  // Data pin output enable
   output logic            bit_clock_pin,   // Bit clock pin output
   output logic            bit_clock_oe,    // Bit clock pin enable
   output logic            mod_data,        // Data to modulator
   output logic            front_amp_bypass,// Front amplifier bypass
   output logic      [1:0] prefilter_cut,   // Prefilter cutoff code
   output logic      [1:0] op_state,        // Operating state
   output logic            sync_active      // Synchronous mode live
);
   // ==========================================================
   // Overview
   // Four control registers are written over the index bus and feed the
   // link side. The data pin is driven only in receive; in transmit the
   // host owns it and must keep it released until it sends, because the
   // pin level reaches the modulator with no filtering.
   // In synchronous receive the bit clock is the programmed bit-rate clock; no phase
   // recovery is done, so the far transmitter must hold the same rate.
   // The bit synchronizer clock field is stored and read back but unused.
   // Outputs are all registered and so trail the register file by a cycle.

   // ==========================================================
   // Reset synchroniser
   // Release ripples through two stages so all registers leave reset together
   logic rst_meta_reg;
   logic rst_sync_n;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n   <= rst_meta_reg;
      end
   end

   // ==========================================================
   // Register file
   logic [7:0] main_control_reg;
   logic [7:0] mod_prefilter_reg;
   logic [7:0] clk_exponent_reg;
   logic [7:0] bitrate_refdiv_reg;
   logic       wr_main;
   logic       wr_modpf;
   logic       wr_exp;
   logic       wr_rate;
   logic [7:0] rdata_next;

   // Index compare shared by the write decode and the read select
   function automatic logic index_hit(input logic [6:0] addr,
                                      input logic [6:0] ofs);
      return addr == ofs;
   endfunction

   // Address decode; a write to an unmapped index is dropped
   assign wr_main  = reg_wr && index_hit(reg_addr, fdi_pkg::OFS_MAIN_CONTROL);
   assign wr_modpf = reg_wr && index_hit(reg_addr, fdi_pkg::OFS_MOD_PREFILTER);
   assign wr_exp   = reg_wr && index_hit(reg_addr, fdi_pkg::OFS_CLK_EXPONENT);
   assign wr_rate  = reg_wr && index_hit(reg_addr, fdi_pkg::OFS_BITRATE_REFDIV);
   // Unmapped indices read as zero
   assign rdata_next =
      index_hit(reg_addr, fdi_pkg::OFS_MAIN_CONTROL)   ? main_control_reg   :
      index_hit(reg_addr, fdi_pkg::OFS_MOD_PREFILTER)  ? mod_prefilter_reg  :
      index_hit(reg_addr, fdi_pkg::OFS_CLK_EXPONENT)   ? clk_exponent_reg   :
      index_hit(reg_addr, fdi_pkg::OFS_BITRATE_REFDIV) ? bitrate_refdiv_reg : 8'h00;

   // Register writes; read data is registered and lags the index by a cycle
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         main_control_reg   <= fdi_pkg::RST_MAIN_CONTROL;
         mod_prefilter_reg  <= fdi_pkg::RST_MOD_PREFILTER;
         clk_exponent_reg   <= fdi_pkg::RST_CLK_EXPONENT;
         bitrate_refdiv_reg <= fdi_pkg::RST_BITRATE_REFDIV;
         reg_rdata          <= 8'h00;
      end else begin
         if (wr_main) main_control_reg <= reg_wdata;
         if (wr_modpf) mod_prefilter_reg <= reg_wdata;
         if (wr_exp) clk_exponent_reg <= reg_wdata;
         if (wr_rate) bitrate_refdiv_reg <= reg_wdata;
         reg_rdata <= rdata_next;
      end
   end

   // ==========================================================
   // Field extraction
   logic          sync_sel;
   logic [1:0]    state_code;
   logic [2:0]    rate_exp;
   logic [5:0]    ref_div;
   fdi_pkg::fdi_op_state_t st;
   logic          is_rx;
   logic          is_tx;
   logic          sync_rx;
   logic          sync_tx;
   logic          clk_run;

   assign sync_sel   = main_control_reg[fdi_pkg::POS_SYNC_SELECT];
   assign state_code = main_control_reg[fdi_pkg::POS_OP_STATE_LO +: 2];
   assign rate_exp   = {clk_exponent_reg[fdi_pkg::POS_EXP_HI],
                        bitrate_refdiv_reg[fdi_pkg::POS_EXP_LO +: 2]};
   assign ref_div    = bitrate_refdiv_reg[fdi_pkg::POS_REFDIV_LO +: 6];
   assign st         = fdi_pkg::fdi_op_state_t'(state_code);

   // State decode
   // Power down and standby leave the link idle: pins released, clock low
   always_comb begin
      is_rx = 1'b0;
      is_tx = 1'b0;
      case (st)
         fdi_pkg::OPS_RECEIVE:  is_rx = 1'b1;
         fdi_pkg::OPS_TRANSMIT: is_tx = 1'b1;
         fdi_pkg::OPS_POWER_DOWN, fdi_pkg::OPS_STANDBY: is_rx = 1'b0;
         default: is_rx = 1'b0;
      endcase
   end
   assign sync_rx = sync_sel && is_rx;
   assign sync_tx = sync_sel && is_tx;
   // Device is link clock master only while a synchronous mode is live
   assign clk_run = sync_rx || sync_tx;

   // ==========================================================
   // Bit clock generation; runs only in synchronous modes
   // Counter restarts when sync drops, so a new mode starts on a clean half period
   logic half_tick;
   fdi_rate_gen #(.CW(CW)) u_rate (
      .clk_sys    (clk_sys),
      .rst_sync_n (rst_sync_n),
      .run        (clk_run),
      .xtal_tick  (xtal_tick),
      .ref_div    (ref_div),
      .exponent   (rate_exp),
      .half_tick  (half_tick)
   );

   // ==========================================================
   // Link datapath
   logic clk_level_next;
   logic rise;
   logic demod_bit;
   logic rx_data_next;
   logic tx_data_next;

   // Synchronous path takes a new bit only at a rising clock, else passes through
   function automatic logic link_next(input logic sync_on,
                                      input logic take,
                                      input logic fresh,
                                      input logic held);
      return (sync_on && !take) ? held : fresh;
   endfunction

   // Clock toggles each half period; forced low outside sync so no stray edge
   assign clk_level_next = clk_run ? (bit_clock_pin ^ half_tick) : 1'b0;
   assign rise           = half_tick && !bit_clock_pin;
   assign demod_bit      = demod_i_lags_q;
   // Receive: transparent, or updated only on rising edge
   assign rx_data_next   = link_next(sync_rx, rise, demod_bit, serial_data_out);
   // Transmit: transparent, or sampled on rising edge
   assign tx_data_next   = link_next(sync_tx, rise, serial_data_in, mod_data);

   // Link pins and modulator data
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bit_clock_pin    <= 1'b0;
         bit_clock_oe     <= 1'b0;
         serial_data_out  <= 1'b0;
         serial_data_oe   <= 1'b0;
         mod_data         <= 1'b0;
      end else begin
         bit_clock_pin    <= clk_level_next;
         bit_clock_oe     <= clk_run;
         serial_data_out  <= rx_data_next;
         serial_data_oe   <= is_rx; // Released in transmit for the host to drive
         mod_data         <= is_tx ? tx_data_next : 1'b0;
      end
   end

   // ==========================================================
   // Configuration outputs
   // Registered copies, so every port comes straight from a flop
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         front_amp_bypass <= 1'b0;
         prefilter_cut    <= fdi_pkg::CUT_100K;
         op_state         <= 2'h0;
         sync_active      <= 1'b0;
      end else begin
         front_amp_bypass <= main_control_reg[fdi_pkg::POS_FRONT_AMP_BYPASS];
         prefilter_cut    <= mod_prefilter_reg[fdi_pkg::POS_PREFILTER_LO +: 2];
         op_state         <= state_code;
         sync_active      <= clk_run;
      end
   end
endmodule // fdi_data_if

// *** testbench/fdi_sva.sv ***
`timescale 1ns/100ps
// ====================
// Port checker
module fdi_sva (
   input wire logic       clk_sys,          // System clock
   input wire logic       rst_n,            // Reset, active low
   input wire logic       reg_wr,           // Write strobe
   input wire logic [6:0] reg_addr,         // Register index
   input wire logic [7:0] reg_wdata,        // Write data
   input wire logic       demod_i_lags_q,   // Demodulator phase
   input wire logic       serial_data_in,   // Data pin level
   input wire logic       serial_data_out,  // Data pin drive
   input wire logic       serial_data_oe,   // Data pin enable
   input wire logic       bit_clock_pin,    // Bit clock level
   input wire logic       bit_clock_oe,     // Bit clock enable
   input wire logic       mod_data,         // Modulator data
   input wire logic       front_amp_bypass, // Front-end bypass
   input wire logic       sync_active,      // Sync mode live
   input wire logic [1:0] prefilter_cut,    // Cutoff code
   input wire logic [1:0] op_state          // Operating state
);
   logic rxa, txa, rxs, txs;
   // Mode qualifiers; $past of them skips mode changes
   assign rxa = op_state == 2'h2 && !sync_active;
   assign txa = op_state == 2'h3 && !sync_active;
   assign rxs = op_state == 2'h2 && sync_active;
   assign txs = op_state == 2'h3 && sync_active;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_wr(logic [6:0] a);
      reg_wr && reg_addr == a;
   endsequence
   a_main_map: assert property (s_wr(fdi_pkg::OFS_MAIN_CONTROL) |-> ##2
      {front_amp_bypass, op_state} == {$past(reg_wdata[7], 2), $past(reg_wdata[2:1], 2)})
      else $error("main fields");
   a_cut_map: assert property (s_wr(fdi_pkg::OFS_MOD_PREFILTER) |-> ##2
      prefilter_cut == $past(reg_wdata[1:0], 2)) else $error("cutoff field");
   a_clk_gate: assert property (bit_clock_oe == sync_active && (sync_active || !bit_clock_pin))
      else $error("bit clock gate");
   a_pin_dir: assert property (serial_data_oe == (op_state == 2'h2)) else $error("pin dir");
   a_rx_pass: assert property (rxa && $past(rxa) |-> serial_data_out == $past(demod_i_lags_q))
      else $error("rx pass");
   a_tx_pass: assert property (txa && $past(txa) |-> mod_data == $past(serial_data_in))
      else $error("tx pass");
   a_tx_rise: assert property (txs && $past(txs) && $rose(bit_clock_pin) |->
      mod_data == $past(serial_data_in)) else $error("tx sample");
   a_rx_rise: assert property (rxs && $past(rxs) && $changed(serial_data_out) |->
      $rose(bit_clock_pin)) else $error("rx update");
endmodule // fdi_sva

// *** testbench/fdi_host.sv ***
`timescale 1ns/100ps
// ====================
// Host controller model
module fdi_host (
   input  wire logic       clk_sys,         // System clock
   input  wire logic       bit_clock_pin,   // Device bit clock
   input  wire logic       send,            // Host drives the pin
   input  wire logic       serial_data_out, // Device data drive
   input  wire logic       serial_data_oe,  // Device drive enable
   input  wire logic [7:0] tx_pattern,      // Bits to send
   output logic            serial_data_in,  // Pin level
   output logic      [7:0] rx_shift         // Bits taken
);
   logic       last = 1'b0, flt = 1'b0;
   logic [7:0] txs = 8'h00;
   // Released pin wanders so a stale level never passes for data
   assign serial_data_in = serial_data_oe ? serial_data_out : send ? txs[7] : flt;
   // Host shifts its send and receive bits on falling bit clock only
   always @(negedge clk_sys) begin
      last <= bit_clock_pin;
      flt <= ~flt;
      if (last && !bit_clock_pin) rx_shift <= {rx_shift[6:0], serial_data_out};
      if (!send) txs <= tx_pattern;
      else if (last && !bit_clock_pin) txs <= {txs[6:0], txs[7]};
   end
endmodule // fdi_host

// *** testbench/test_fsk_data_interface_bitclock.sv ***
`timescale 1ns/100ps
// ====================
// Bench: register calls, then each mode
module test_fsk_data_interface_bitclock;
   logic       clk_sys = 1'b0, rst_n = 1'b0, xtal_tick = 1'b0, reg_wr = 1'b0, send = 1'b0;
   logic       demod_i_lags_q = 1'b0, bprev = 1'b0, p;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rx_shift, e;
   logic [1:0] prefilter_cut, op_state;
   logic       serial_data_in, serial_data_out, serial_data_oe, bit_clock_pin, bit_clock_oe;
   logic       mod_data, front_amp_bypass, sync_active;
   logic [2:0] re [4] = '{3'h0, 3'h6, 3'h5, 3'h6};
   logic [5:0] rk [4] = '{6'h01, 6'h3f, 6'h03, 6'h01};
   int         miscompares = 0, checked = 0, n;
   fdi_data_if #(.CW(13)) DUT (.clk_sys, .rst_n, .xtal_tick, .reg_wr, .reg_addr, .reg_wdata,
      .reg_rdata, .demod_i_lags_q, .serial_data_in, .serial_data_out, .serial_data_oe,
      .bit_clock_pin, .bit_clock_oe, .mod_data, .front_amp_bypass, .prefilter_cut, .op_state,
      .sync_active);
   fdi_host HOST (.clk_sys, .bit_clock_pin, .send, .serial_data_out, .serial_data_oe,
      .tx_pattern(8'h96), .serial_data_in, .rx_shift);
   initial forever #2.5 clk_sys = ~clk_sys;
   // Crystal enable every other cycle; bit clock history
   always @(negedge clk_sys) begin
      xtal_tick <= ~xtal_tick;
      bprev <= bit_clock_pin;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Returns once derived outputs have landed
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_sys) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      repeat (3) @(negedge clk_sys) reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] x);
      @(negedge clk_sys) reg_addr = a;
      @(negedge clk_sys) chk(reg_rdata, x);
   endtask
   // Cycles to the next rising bit clock, bounded
   task automatic rise(output int c);
      c = 0;
      do @(negedge clk_sys) c++; while ((bprev || !bit_clock_pin) && c < 600);
      // A bit clock that never rises counts as a mismatch
      if (c >= 600) chk(8'h01, 8'h00);
   endtask
   task automatic wrap_up;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      wrap_up;
   end
   initial begin
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      rd(7'h07, 8'h01);
      wr(7'h02, 8'hff);
      rd(7'h02, 8'h00);
      // Every state, sync off; cutoff code follows the state
      for (int s = 0; s < 4; s++) begin
         wr(7'h01, 8'(s));
         wr(7'h00, 8'h80 | 8'(s << 1));
         chk({bit_clock_oe, sync_active, bit_clock_pin, prefilter_cut, front_amp_bypass, op_state},
             {3'h0, 2'(s), 1'b1, 2'(s)});
         rd(7'h01, 8'(s));
         repeat (4) begin
            demod_i_lags_q = ~demod_i_lags_q;
            @(posedge clk_sys) p = serial_data_in;
            e = {5'h0, s == 2, s == 2 && demod_i_lags_q, s == 3 && p};
            @(negedge clk_sys);
            chk({5'h0, serial_data_oe, serial_data_oe & serial_data_out, mod_data}, e);
         end
      end
      wr(7'h00, 8'h0e);
      chk({5'h0, front_amp_bypass, bit_clock_oe, sync_active}, 8'h03);
      foreach (rk[i]) begin
         wr(7'h06, {7'h00, re[i][2]});
         wr(7'h07, {re[i][1:0], rk[i]});
         repeat (3) rise(n);
         chk(8'(n / 2), {2'h0, rk[i]} << (7 - re[i]));
      end
      send = 1'b1;
      repeat (8) begin
         rise(n);
         chk({7'h0, mod_data}, {7'h0, serial_data_in});
      end
      send = 1'b0;
      // Receive at a slower rate, synchronizer clock at sixteen times it
      wr(7'h06, 8'h0c);
      wr(7'h07, 8'h81);
      rd(7'h06, 8'h0c);
      wr(7'h00, 8'h0c);
      chk({6'h0, serial_data_oe, bit_clock_oe}, 8'h03);
      for (int v = 0; v < 2; v++) begin
         demod_i_lags_q = v[0];
         repeat (10) rise(n);
         chk(rx_shift, {8{v[0]}});
      end
      wrap_up;
   end
endmodule // test_fsk_data_interface_bitclock
bind fdi_data_if fdi_sva SVA (.clk_sys, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .demod_i_lags_q,
   .serial_data_in, .serial_data_out, .serial_data_oe, .bit_clock_pin, .bit_clock_oe, .mod_data,
   .front_amp_bypass, .prefilter_cut, .op_state, .sync_active);
